// ==== hw/pss_pkg.sv ====
// Package for the panel supply sequencer: register map, reset values,
// timing constants, state encoding and the struct carriers.
// Assumes a 20 MHz core clock and an AXI4-Lite master with 32-bit data.
package pss_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned SS_RAMP_US      = 14_000;     // Whole soft-start ramp
    localparam int unsigned SS_STEPS        = 128;
    // Shortest-time rounding: floor of the per-step period in cycles
    localparam int unsigned SS_TICK_CYCLES  = (SS_RAMP_US * (CLK_HZ / 1_000_000)) / SS_STEPS;
    localparam int unsigned FAULT_MS        = 200;
    localparam int unsigned FAULT_CYCLES    = FAULT_MS * (CLK_HZ / 1_000);
    localparam logic [7:0]  SS_LAST         = 8'h80;      // Step count once ramp is done
    localparam logic [6:0]  SS_CODE_FULL    = 7'h7f;

    // ****************************************************************
    // Register map (byte addresses) and reset values
    // ****************************************************************
    localparam logic [31:0] ADDR_DELAY      = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS     = 32'h0000_0004;
    localparam logic [31:0] ADDR_SS_CODES   = 32'h0000_0008;
    localparam logic [31:0] DELAY_RST       = 32'h0000_4e20;  // 1 ms at 20 MHz
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_DECERR     = 2'h3;

    // Status word field positions
    localparam int unsigned ST_STATE_LSB    = 0;   // 3 bits
    localparam int unsigned ST_LATCH        = 4;
    localparam int unsigned ST_THERMAL      = 5;
    localparam int unsigned ST_SS_DONE      = 6;
    localparam int unsigned ST_PINS_LSB     = 8;   // 7 filtered pins

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_LOCKOUT, ST_WAIT_REF, ST_SOFT_START, ST_DELAY, ST_RUN, ST_FAULT
    } pss_state_t;

    typedef struct packed {
        logic        undervoltage_lockout_ok;  // Input above lockout threshold
        logic        ref_ready;                // Reference above enable level
        logic        over_temp;
        logic        switch_select;
        logic [2:0]  fault_cmp;                // Output below detection level
    } pss_pins_t;

    typedef struct packed {
        logic        step_up_en;
        logic        gate_on_en;
        logic        gate_off_en;
        logic        amp_hiz;
        logic        delay_cap_discharge;
        logic        switch_ctrl_en;
        logic        source_switch;
        logic        drain_switch;
        logic        fault_latched;
        logic [6:0]  step_up_code;
        logic [6:0]  gate_on_code;
        logic [6:0]  gate_off_code;
    } pss_out_t;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } pss_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pss_axi_rsp_t;

endpackage : pss_pkg

// ==== hw/pss_sequencer.sv ====
// Panel supply sequencer: lockout gating, three soft-start ramps,
// startup delay, switch selector, fault timer and thermal fault latch.
// Assumes pin inputs are asynchronous and the registers are reached
// over AXI4-Lite with one write and one read in flight at most.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps

// Summary of operation
// - Start sequence only after lockout rising threshold
// - Lockout turns off regulators, switches; amplifiers hiz
// - Reference ready enables all three regulators together
// - Each regulator has own seven-bit soft-start code
// - Step-up, gate-on codes ramp up 128 steps
// - Gate-off code ramps down to 250mV, 128 steps
// - All three ramps last 14ms
// - Each enable restarts ramp from initial code
// - Delay starts after lockout, soft-start, no fault
// - Delay terminal count enables switch control
// - Delay timer held cleared before startup, lockout
// - Select ignored until all four conditions hold
// - Select high: source on, drain off; low reverse
// - Fault timer runs while any output low
// - Persisting fault 200ms sets latch, shuts outputs
// - Only a supply cycle clears the fault latch
// - Fault timer held inactive during soft-start
// - Over-temperature sets latch at once, shuts outputs
// - Thermal latch survives cooling until supply cycle
// - Inhibited switch control ignores the select input
module pss_sequencer
#(
    parameter int unsigned FAULT_TIMER_CYCLES = pss_pkg::FAULT_CYCLES,
    // A shorter step lets a bench run a whole ramp in few cycles
    parameter int unsigned STEP_TICK_CYCLES   = pss_pkg::SS_TICK_CYCLES
)
(
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire pss_pkg::pss_pins_t    pins,
    input  wire pss_pkg::pss_axi_req_t axi_req,
    output pss_pkg::pss_axi_rsp_t      axi_rsp,
    output pss_pkg::pss_out_t          pwr
);
    import pss_pkg::*;

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        logic [6:0]  sync1;
        logic [6:0]  sync2;
        logic [6:0]  sync3;
        logic [6:0]  filt;
        pss_state_t  state;
        logic        latch;
        logic        thermal;
        logic [11:0] presc;
        logic [7:0]  step;
        logic [31:0] dly_cnt;
        logic [31:0] dly_limit;
        logic [22:0] ftimer;
        logic        aw_held;
        logic [31:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        pss_out_t    out;
    } pss_regs_t;

    pss_regs_t s_q;
    pss_regs_t s_d;

    pss_pins_t  in_f;
    logic       tick;
    logic       ss_done;
    logic       fault_any;
    logic       timer_live;
    logic       go_fault;
    logic       wr_fire;
    logic [31:0] status_word;
    logic [31:0] codes_word;

    assign in_f = pss_pins_t'(s_q.filt);

    // Shared step tick and ramp-complete flag
    assign tick      = (s_q.presc == 12'(STEP_TICK_CYCLES - 1));
    assign ss_done   = (s_q.step == SS_LAST);
    assign fault_any = |in_f.fault_cmp;
    // Timer only counts after the ramps, never while they are climbing
    assign timer_live = fault_any && ((s_q.state == ST_DELAY)
                        || (s_q.state == ST_RUN));
    assign go_fault  = in_f.over_temp
                    || (timer_live
                        && (s_q.ftimer == 23'(FAULT_TIMER_CYCLES - 1)));
    assign wr_fire   = s_q.aw_held && s_q.w_held && !s_q.bvalid;

    // Read-back words
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_STATE_LSB +: 3] = s_q.state;
        status_word[ST_LATCH]          = s_q.latch;
        status_word[ST_THERMAL]        = s_q.thermal;
        status_word[ST_SS_DONE]        = ss_done;
        status_word[ST_PINS_LSB +: 7]  = s_q.filt;
        codes_word = {9'h000, s_q.out.gate_off_code, 1'b0, s_q.out.gate_on_code,
                      1'b0, s_q.out.step_up_code};
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;

        // Three-stage pin sampling; a change counts once stages two and
        // three agree, so a single-cycle glitch never reaches the sequencer
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;
        s_d.filt  = (~(s_q.sync2 ^ s_q.sync3) & s_q.sync3)
                  | ((s_q.sync2 ^ s_q.sync3) & s_q.filt);

        // Fault latch: only a supply drop clears it, and a set in the
        // same cycle as that drop still wins
        if (!in_f.undervoltage_lockout_ok)
        begin
            s_d.latch   = 1'b0;
            s_d.thermal = 1'b0;
        end
        if (go_fault)
        begin
            s_d.latch = 1'b1;
        end
        if (in_f.over_temp)
        begin
            s_d.thermal = 1'b1;
        end

        // Fault timer needs an unbroken fault; any gap restarts it
        s_d.ftimer = timer_live ? s_q.ftimer + 23'h000001 : 23'h000000;

        // Prescaler runs only while the ramps step
        s_d.presc = (s_q.state == ST_SOFT_START && !tick)
                  ? s_q.presc + 12'h001 : 12'h000;

        unique case (s_q.state)
            ST_LOCKOUT:
            begin
                if (in_f.undervoltage_lockout_ok)
                begin
                    s_d.state = ST_WAIT_REF;
                end
            end
            ST_WAIT_REF:
            begin
                s_d.step = 8'h00;
                if (in_f.ref_ready)
                begin
                    s_d.state = ST_SOFT_START;
                end
            end
            ST_SOFT_START:
            begin
                if (ss_done)
                begin
                    s_d.state   = ST_DELAY;
                    s_d.dly_cnt = 32'h0000_0000;
                end
                else if (tick)
                begin
                    s_d.step = s_q.step + 8'h01;
                end
            end
            ST_DELAY:
            begin
                if (s_q.dly_cnt >= s_q.dly_limit)
                begin
                    s_d.state = ST_RUN;
                end
                else
                begin
                    s_d.dly_cnt = s_q.dly_cnt + 32'h0000_0001;
                end
            end
            ST_RUN:
            begin
                s_d.state = ST_RUN;
            end
            ST_FAULT:
            begin
                s_d.state = ST_FAULT;
            end
        endcase

        // A set latch overrides everything but a supply drop
        if (s_d.latch)
        begin
            s_d.state = ST_FAULT;
        end
        if (!in_f.undervoltage_lockout_ok)
        begin
            s_d.state   = ST_LOCKOUT;
            s_d.step    = 8'h00;
            s_d.dly_cnt = 32'h0000_0000;
        end

        // ************************************************************
        // AXI4-Lite slave: address and data taken in either order
        // ************************************************************
        if (axi_req.awvalid && !s_q.aw_held)
        begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !s_q.w_held)
        begin
            s_d.w_held = 1'b1;
            s_d.w_data = axi_req.wdata;
            s_d.w_strb = axi_req.wstrb;
        end
        if (wr_fire)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = RESP_OKAY;
            if ({s_q.aw_addr[31:2], 2'b00} == ADDR_DELAY)
            begin
                for (int b = 0; b < 4; b++)
                begin
                    if (s_q.w_strb[b])
                    begin
                        s_d.dly_limit[8*b +: 8] = s_q.w_data[8*b +: 8];
                    end
                end
            end
            else if ({s_q.aw_addr[31:2], 2'b00} != ADDR_STATUS
                  && {s_q.aw_addr[31:2], 2'b00} != ADDR_SS_CODES)
            begin
                s_d.bresp = RESP_DECERR;    // Unmapped words answer DECERR; read-only words accept and ignore
            end
        end
        if (s_q.bvalid && axi_req.bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // Read: one cycle from address to data
        if (axi_req.arvalid && !s_q.rvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            unique case ({axi_req.araddr[31:2], 2'b00})
                ADDR_DELAY:    s_d.rdata = s_q.dly_limit;
                ADDR_STATUS:   s_d.rdata = status_word;
                ADDR_SS_CODES: s_d.rdata = codes_word;
                default:
                begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = RESP_DECERR;
                end
            endcase
        end
        else if (s_q.rvalid && axi_req.rready)
        begin
            s_d.rvalid = 1'b0;
        end

        // ************************************************************
        // Registered outputs, computed from the next state
        // ************************************************************
        s_d.out = '0;
        s_d.out.fault_latched = s_d.latch;
        // Regulators live from reference-ready until fault or lockout
        if (s_d.state == ST_SOFT_START || s_d.state == ST_DELAY
            || s_d.state == ST_RUN)
        begin
            s_d.out.step_up_en  = 1'b1;
            s_d.out.gate_on_en  = 1'b1;
            s_d.out.gate_off_en = 1'b1;
        end
        // Amplifiers float in lockout and after a fault
        s_d.out.amp_hiz = (s_d.state == ST_LOCKOUT)
                       || (s_d.state == ST_FAULT);
        // Cap node held discharged until the delay may start
        s_d.out.delay_cap_discharge = (s_d.state != ST_DELAY)
                                   && (s_d.state != ST_RUN);
        // Up ramps count 0..127; down ramp mirrors, 127 is full reference
        s_d.out.step_up_code  = (s_d.step == SS_LAST) ? SS_CODE_FULL
                              : s_d.step[6:0];
        s_d.out.gate_on_code  = s_d.out.step_up_code;
        s_d.out.gate_off_code = ~s_d.out.step_up_code;
        if (s_d.state == ST_RUN)
        begin
            s_d.out.switch_ctrl_en = 1'b1;
            s_d.out.source_switch  = in_f.switch_select;
            s_d.out.drain_switch   = !in_f.switch_select;
        end
        // Outside RUN both switches stay open whatever the select does
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q                         <= '0;
            s_q.state                   <= ST_LOCKOUT;
            s_q.dly_limit               <= DELAY_RST;
            s_q.out.amp_hiz             <= 1'b1;
            s_q.out.delay_cap_discharge <= 1'b1;
            s_q.out.gate_off_code       <= SS_CODE_FULL;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Handshake outputs
    assign axi_rsp.awready = !s_q.aw_held;
    assign axi_rsp.wready  = !s_q.w_held;
    assign axi_rsp.bvalid  = s_q.bvalid;
    assign axi_rsp.bresp   = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid  = s_q.rvalid;
    assign axi_rsp.rdata   = s_q.rdata;
    assign axi_rsp.rresp   = s_q.rresp;
    assign pwr             = s_q.out;

endmodule : pss_sequencer

// ==== test/pss_panel_tcon.sv ====
// Model of the panel timing controller that drives the switch-select level.
// Assumes one core clock; the level moves only just after a rising edge.
`timescale 1ns/10ps
module pss_panel_tcon
(
    input  wire logic core_clk,
    input  wire logic rstn,
    output logic      switch_select = 1'b0
);
    int unsigned hold_q = 0;

    // Toggle after a random hold so the block meets both levels at any time
    always @(posedge core_clk)
    begin
        if (!rstn)
            hold_q <= 5;
        else if (hold_q == 0)
        begin
            switch_select <= ~switch_select;
            hold_q        <= $urandom_range(40, 3);
        end
        else
            hold_q <= hold_q - 1;
    end
endmodule : pss_panel_tcon

// ==== test/pss_sequencer_sva.sv ====
// Checker for the panel supply sequencer, tied to the top-level ports only.
// Assumes a single core clock domain and the active-low reset rstn.
`timescale 1ns/10ps
module pss_sequencer_sva
#(
    parameter int unsigned FAULT_TIMER_CYCLES = 50
)
(
    input wire logic                  core_clk,
    input wire logic                  rstn,
    input wire pss_pkg::pss_pins_t    pins,
    input wire pss_pkg::pss_axi_req_t axi_req,
    input wire pss_pkg::pss_axi_rsp_t axi_rsp,
    input wire pss_pkg::pss_out_t     pwr
);
    import pss_pkg::*;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Margin of six samples covers the three-flop pin filter
    lockout_off_a: assert property (!pins.undervoltage_lockout_ok [*6] |=>
        !pwr.step_up_en && pwr.amp_hiz && !pwr.switch_ctrl_en) else $error("lockout left on");
    enables_joint_a: assert property (pwr.step_up_en == pwr.gate_on_en
        && pwr.gate_on_en == pwr.gate_off_en) else $error("enables split");
    code_pair_a: assert property (pwr.gate_on_code == pwr.step_up_code
        && pwr.gate_off_code == ~pwr.step_up_code) else $error("codes disagree");
    ramp_restart_a: assert property ($rose(pwr.step_up_en) |->
        pwr.step_up_code == 7'h00 && pwr.gate_off_code == SS_CODE_FULL) else $error("no restart");
    step_by_one_a: assert property (pwr.step_up_en && $past(pwr.step_up_en) &&
        $changed(pwr.step_up_code) |-> pwr.step_up_code == $past(pwr.step_up_code) + 7'h01)
        else $error("ramp skipped");
    switch_idle_a: assert property (!pwr.switch_ctrl_en |->
        !pwr.source_switch && !pwr.drain_switch) else $error("switch moved");
    switch_gate_a: assert property (pwr.switch_ctrl_en |-> pwr.step_up_en
        && !pwr.delay_cap_discharge && !pwr.amp_hiz) else $error("switch early");
    select_follow_a: assert property (pwr.switch_ctrl_en |->
        pwr.source_switch != pwr.drain_switch) else $error("switch pair wrong");
    thermal_set_a: assert property (pins.over_temp [*3] |-> ##5 pwr.fault_latched)
        else $error("thermal not latched");
    latch_hold_a: assert property ((pwr.fault_latched &&
        pins.undervoltage_lockout_ok) [*6] |=> pwr.fault_latched) else $error("latch lost");
    latch_shut_a: assert property (pwr.fault_latched [*2] |-> !pwr.step_up_en
        && !pwr.switch_ctrl_en && pwr.amp_hiz) else $error("latch left on");
endmodule : pss_sequencer_sva

// ==== test/pss_sequencer_bench.sv ====
// Self-checking bench for the panel supply sequencer.
// Assumes the package, the checker and the controller model compile first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module pss_sequencer_bench;
    import pss_pkg::*;
    // ****************************************************************
    // Environment
    // ****************************************************************
    logic         core_clk = 0, rstn = 0, uv_ok = 0, ref_ok = 0, otmp = 0, sel;
    logic [2:0]   fcmp = 0;
    pss_axi_req_t req = '0;
    pss_axi_rsp_t rsp;
    pss_out_t     pwr;
    logic [31:0]  rd, dly, wv;
    logic [3:0]   st;
    logic [1:0]   rs;
    int           fail_count = 0, n_compared = 0, n;
    logic [4:0]   sel_h = '0;
    localparam int unsigned TICK = 40;
    localparam int unsigned FT   = 50;
    localparam logic [31:0] DLY  = 32'h0000_001e;

    always #25 core_clk = ~core_clk;

    // Select level as the switches should show it five edges later
    always @(posedge core_clk) sel_h <= {sel_h[3:0], sel};

    pss_sequencer #(.FAULT_TIMER_CYCLES(FT), .STEP_TICK_CYCLES(TICK)) u_pss_sequencer (
        .core_clk(core_clk), .rstn(rstn), .pins({uv_ok, ref_ok, otmp, sel, fcmp}),
        .axi_req(req), .axi_rsp(rsp), .pwr(pwr));
    pss_panel_tcon u_pss_panel_tcon (.core_clk(core_clk), .rstn(rstn),
        .switch_select(sel));

    task cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc

    // Ready is sampled at the falling edge; it only moves on rising edges
    task axw(input logic [31:0] a, d, input logic [3:0] s, output logic [1:0] r);
        logic ad, wd, at, wt;
        ad = 0;
        wd = 0;
        @(posedge core_clk);
        req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1;
        req.wdata <= d; req.wstrb <= s; req.bready <= 1;
        while (!(ad && wd))
        begin
            @(negedge core_clk);
            at = rsp.awready & ~ad;
            wt = rsp.wready & ~wd;
            @(posedge core_clk);
            if (at) req.awvalid <= 0;
            if (wt) req.wvalid <= 0;
            ad |= at;
            wd |= wt;
        end
        do @(negedge core_clk); while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        @(posedge core_clk);
        req.bready <= 0;
    endtask : axw

    task axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
        do @(negedge core_clk); while (rsp.arready !== 1'b1);
        @(posedge core_clk);
        req.arvalid <= 0;
        do @(negedge core_clk); while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        @(posedge core_clk);
        req.rready <= 0;
    endtask : axr

    function automatic logic [31:0] merge(logic [31:0] o, n, logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = n[8*i +: 8];
        return o;
    endfunction : merge

    // Gate-off code counts down from full as the others count up
    function automatic logic [6:0] exp_off(logic [6:0] c);
        return SS_CODE_FULL - c;
    endfunction : exp_off

    task conclude;
        $display("counts: %0d compared, %0d mismatches", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // Watchdog sized well above one short ramp, the delay and the fault timer
    initial
    begin
        #2_500_000;
        fail_count++;
        conclude();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        void'($urandom(32'h5ff46c6f));
        repeat (16) @(posedge core_clk);
        rstn <= 1;
        cyc(2);
        `CHK("enables", 3'b000, {pwr.step_up_en, pwr.gate_on_en, pwr.gate_off_en})
        `CHK("hiz", 1'b1, pwr.amp_hiz)
        `CHK("discharge", 1'b1, pwr.delay_cap_discharge)
        `CHK("off code", SS_CODE_FULL, pwr.gate_off_code)
        axr(ADDR_DELAY, rd, rs);
        `CHK("delay reset", DELAY_RST, rd)
        $display("test reset done");
        // Random words with random byte strobes, the first one full
        dly = DELAY_RST;
        for (n = 0; n < 6; n++)
        begin
            wv = $urandom;
            st = (n == 0) ? 4'hf : 4'($urandom);
            axw(ADDR_DELAY, wv, st, rs);
            dly = merge(dly, wv, st);
            axr(ADDR_DELAY, rd, rs);
            `CHK("delay rw", dly, rd)
        end
        axw(ADDR_DELAY, DLY, 4'hf, rs);
        `CHK("delay set", RESP_OKAY, rs)
        axw(ADDR_STATUS, 32'hffff_ffff, 4'hf, rs);
        `CHK("ro write", RESP_OKAY, rs)
        axw(32'h0000_0040, 32'h0, 4'hf, rs);
        `CHK("bad write", RESP_DECERR, rs)
        axr(32'h0000_0040, rd, rs);
        `CHK("bad read", RESP_DECERR, rs)
        `CHK("bad data", 32'h0, rd)
        $display("test registers done");
        // Supply up but reference not ready: nothing may start
        @(posedge core_clk) uv_ok <= 1;
        cyc(10);
        axr(ADDR_STATUS, rd, rs);
        `CHK("wait ref", ST_WAIT_REF, rd[2:0])
        `CHK("no enable", 1'b0, pwr.step_up_en)
        @(posedge core_clk)
        begin
            ref_ok <= 1;
            fcmp   <= 3'($urandom_range(7, 1));
        end
        do @(negedge core_clk); while (pwr.step_up_en !== 1'b1);
        `CHK("together", 3'b111, {pwr.step_up_en, pwr.gate_on_en, pwr.gate_off_en})
        `CHK("start code", 7'h00, pwr.step_up_code)
        do @(negedge core_clk); while (pwr.step_up_code !== 7'h01);
        n = 0;
        while (pwr.step_up_code !== 7'h02 && n < 3000)
        begin
            cyc(1);
            n++;
        end
        `CHK("step period", TICK, n)
        `CHK("tick const", 32'h0000_088b, SS_TICK_CYCLES)
        `CHK("gate on code", 7'h02, pwr.gate_on_code)
        `CHK("gate off code", exp_off(7'h02), pwr.gate_off_code)
        `CHK("no ramp fault", 1'b0, pwr.fault_latched)
        `CHK("switches idle", 2'b00, {pwr.source_switch, pwr.drain_switch})
        $display("test ramp done");
        // Short over-temperature pulse, then cooling
        @(posedge core_clk)
        begin
            fcmp <= 0;
            otmp <= 1;
        end
        cyc(3);
        @(posedge core_clk) otmp <= 0;
        cyc(8);
        `CHK("thermal latch", 1'b1, pwr.fault_latched)
        `CHK("shut", 2'b00, {pwr.step_up_en, pwr.gate_off_en})
        `CHK("shut hiz", 2'b01, {pwr.switch_ctrl_en, pwr.amp_hiz})
        cyc(200);
        axr(ADDR_STATUS, rd, rs);
        `CHK("cause", 2'b11, rd[5:4])
        `CHK("fault state", ST_FAULT, rd[2:0])
        // Supply cycle clears the latch and restarts the ramps
        @(posedge core_clk) uv_ok <= 0;
        cyc(8);
        `CHK("cleared", 1'b0, pwr.fault_latched)
        axr(ADDR_STATUS, rd, rs);
        `CHK("lockout", ST_LOCKOUT, rd[2:0])
        @(posedge core_clk) uv_ok <= 1;
        do @(negedge core_clk); while (pwr.step_up_en !== 1'b1);
        `CHK("restart code", 7'h00, pwr.step_up_code)
        // Count the whole restarted ramp; one more edge leaves the ramp state
        n = 0;
        while (pwr.delay_cap_discharge !== 1'b0 && n < 20000)
        begin
            cyc(1);
            n++;
            if (n == TICK + 20)
                `CHK("one step", 7'h01, pwr.step_up_code)
        end
        `CHK("ramp time", SS_STEPS * TICK + 1, n)
        `CHK("ramp end", {7'h7f, 7'h00}, {pwr.step_up_code, pwr.gate_off_code})
        n = 0;
        while (pwr.switch_ctrl_en !== 1'b1 && n < 1000)
        begin
            cyc(1);
            n++;
        end
        `CHK("delay time", DLY + 1, n)
        for (n = 0; n < 200; n++)
        begin
            cyc(1);
            `CHK("sel", {sel_h[4], ~sel_h[4]}, {pwr.source_switch, pwr.drain_switch})
        end
        axr(ADDR_SS_CODES, rd, rs);
        `CHK("codes word", 32'h0000_7f7f, rd)
        $display("test run done");
        // A broken fault restarts the timer; an unbroken one latches
        @(posedge core_clk) fcmp <= 3'($urandom_range(7, 1));
        cyc(20);
        @(posedge core_clk) fcmp <= 3'h0;
        cyc(60);
        `CHK("gap no latch", 1'b0, pwr.fault_latched)
        @(posedge core_clk) fcmp <= 3'($urandom_range(7, 1));
        n = 0;
        while (pwr.fault_latched !== 1'b1 && n < 1000)
        begin
            cyc(1);
            n++;
        end
        // Pin sampling and the output register add five edges
        `CHK("fault time", FT + 5, n)
        `CHK("timer shut", 3'b001, {pwr.step_up_en, pwr.switch_ctrl_en, pwr.amp_hiz})
        axr(ADDR_STATUS, rd, rs);
        `CHK("timer cause", 2'b01, rd[5:4])
        @(posedge core_clk) uv_ok <= 0;
        cyc(8);
        `CHK("drop", 2'b00, {pwr.step_up_en, pwr.gate_on_en})
        `CHK("drop hiz", 2'b01, {pwr.switch_ctrl_en, pwr.amp_hiz})
        `CHK("drop code", SS_CODE_FULL, pwr.gate_off_code)
        $display("test fault done");
        conclude();
    end
endmodule : pss_sequencer_bench

bind pss_sequencer pss_sequencer_sva #(.FAULT_TIMER_CYCLES(FAULT_TIMER_CYCLES)) u_sva (
    .core_clk(core_clk), .rstn(rstn), .pins(pins), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .pwr(pwr));
